/* verilog/slps_cfg.svh */
// Purpose: offsets, field positions, reset values and codes for slps_regs
// Assumes: register indices are word indices; byte address = index * 4
// Notes: definitions only
`ifndef SLPS_CFG_SVH
`define SLPS_CFG_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define SLPS_IDX_LINK_ID 10'h206
`define SLPS_IDX_FRAME_END_CHAR_SELECT 10'h207
`define SLPS_IDX_STATUS 10'h208
`define SLPS_IDX_IRQ_STAT 10'h2f0
`define SLPS_IDX_IRQ_MASK 10'h2f1
`define SLPS_IDX_CTRL 10'h2f2
`define SLPS_LANE_OFS 2'h0

// ----------------------------------------
// reset values
// ----------------------------------------
`define SLPS_RST_LINK_ID 8'h00
`define SLPS_RST_FRAME_END_CHAR_SELECT 2'h0
`define SLPS_RST_MASK 2'h0

// ----------------------------------------
// status and control bit positions
// ----------------------------------------
`define SLPS_B_LINK_UP 6
`define SLPS_B_SYNC 5
`define SLPS_B_REALIGN 4
`define SLPS_B_ALIGN 3
`define SLPS_B_SPLL 2
`define SLPS_B_CPLL 0
`define SLPS_B_EN 0

// ----------------------------------------
// interrupt bit positions
// ----------------------------------------
`define SLPS_I_REALIGN 0
`define SLPS_I_ALIGN 1

// ----------------------------------------
// end-of-frame selection and control codes
// ----------------------------------------
`define SLPS_SEL_K28_1 2'h1
`define SLPS_SEL_K28_5 2'h2
`define SLPS_K28_7 8'hfc
`define SLPS_K28_1 8'h3c
`define SLPS_K28_5 8'hbc
`define SLPS_PAD24 24'h000000

`endif

/* verilog/slps_pkg.sv */
// Purpose: types shared by the serial link parameter and status registers
// Assumes: constants live in slps_cfg.svh
// Notes: state of slps_regs is one packed struct
package slps_pkg;

    // octet offered by the lane encoder
    typedef struct packed {
        logic valid;
        logic frame_end;
        logic subst_ok;
        logic ila_id_slot;
        logic [7:0] data;
    } slps_octet_t;

    // character handed back to the lane encoder
    typedef struct packed {
        logic valid;
        logic is_k;
        logic [7:0] data;
    } slps_txchar_t;

    typedef struct packed {
        logic [7:0] link_id;
        logic [1:0] frame_end_char_select_sel;
        logic link_en;
        logic link_en_d;
        logic armed;
        logic realigned;
        logic multiframe_phase_set;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic sync_a;
        logic sync_b;
        logic spll_a;
        logic spll_b;
        logic cpll_a;
        logic cpll_b;
        logic [7:0] rdata;
        logic pready;
        logic pslverr;
        logic irq;
        slps_txchar_t tx;
    } slps_state_t;

endpackage

/* verilog/slps_regs.sv */
// Purpose: serial link identifier, end-of-frame select and link status registers
// Assumes: APB slave on pclk; encoder, link and sysref inputs on pclk
// Notes: pll locks and sync_n come from other domains and are synchronised
//
// Contract
// - send link identifier in ILA second multiframe
// - select 0 K28.7, 1 K28.1, 2 K28.5
// - end-of-frame char inserted only when allowed
// - end-of-frame select acts in 8B/10B only
// - status bit 6 shows link up
// - status bit 5 shows sync level
// - bit 4 set on sysref phase shift, sticky
// - writing 1 clears alignment flags, 0 keeps
// - bit 3 set by first sysref after enable
// - bit 2 shows serializer pll lock
// - bit 0 shows converter pll lock
`timescale 1ns/100ps
`include "slps_cfg.svh"

module slps_regs import slps_pkg::*; (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link state sources
    input wire logic link_up,
    input wire logic sync_n,
    input wire logic serializer_pll_lock,
    input wire logic converter_pll_lock,
    input wire logic sysref_evt,
    input wire logic sysref_shift,
    // lane encoder
    input wire logic mode_8b10b,
    input wire slps_octet_t oct,
    output slps_txchar_t tx,
    output logic serial_link_enable,
    // interrupt
    output logic irq
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
        hit = (a[11:2] == idx) && (a[1:0] == `SLPS_LANE_OFS);
    endfunction

    function automatic logic [7:0] eof_char(input logic [1:0] sel);
        case (sel)
            `SLPS_SEL_K28_1: eof_char = `SLPS_K28_1;
            `SLPS_SEL_K28_5: eof_char = `SLPS_K28_5;
            // reserved code falls back to the compliant character
            default: eof_char = `SLPS_K28_7;
        endcase
    endfunction

    localparam slps_state_t RST_STATE = '{
        link_id: `SLPS_RST_LINK_ID,
        frame_end_char_select_sel: `SLPS_RST_FRAME_END_CHAR_SELECT,
        irq_mask: `SLPS_RST_MASK,
        default: '0
    };

    slps_state_t s;
    slps_state_t next_s;
    logic setup;
    logic acc;
    logic wr_ok;
    logic [7:0] stat_val;

    assign setup = psel && !penable;
    assign acc = psel && penable && s.pready;
    assign wr_ok = acc && pwrite && !s.pslverr && pstrb[0];

    // ----------------------------------------
    // status view
    // ----------------------------------------
    always_comb begin
        stat_val = 8'h00;
        stat_val[`SLPS_B_LINK_UP] = link_up;
        stat_val[`SLPS_B_SYNC] = s.sync_b;
        stat_val[`SLPS_B_REALIGN] = s.realigned;
        stat_val[`SLPS_B_ALIGN] = s.multiframe_phase_set;
        stat_val[`SLPS_B_SPLL] = s.spll_b;
        stat_val[`SLPS_B_CPLL] = s.cpll_b;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        if (ce) begin
            // live sources, two flops each
            next_s.sync_a = sync_n;
            next_s.sync_b = s.sync_a;
            next_s.spll_a = serializer_pll_lock;
            next_s.spll_b = s.spll_a;
            next_s.cpll_a = converter_pll_lock;
            next_s.cpll_b = s.cpll_a;
            next_s.link_en_d = s.link_en;

            // bus: decode in setup, answer one cycle later
            next_s.pready = setup;
            if (setup) begin
                next_s.pslverr = 1'b0;
                next_s.rdata = 8'h00;
                if (hit(paddr, `SLPS_IDX_LINK_ID)) begin
                    next_s.rdata = s.link_id;
                end else if (hit(paddr, `SLPS_IDX_FRAME_END_CHAR_SELECT)) begin
                    next_s.rdata = {6'h00, s.frame_end_char_select_sel};
                end else if (hit(paddr, `SLPS_IDX_STATUS)) begin
                    next_s.rdata = stat_val;
                end else if (hit(paddr, `SLPS_IDX_IRQ_STAT)) begin
                    next_s.rdata = {6'h00, s.irq_stat};
                end else if (hit(paddr, `SLPS_IDX_IRQ_MASK)) begin
                    next_s.rdata = {6'h00, s.irq_mask};
                end else if (hit(paddr, `SLPS_IDX_CTRL)) begin
                    next_s.rdata = {7'h00, s.link_en};
                end else begin
                    next_s.pslverr = 1'b1;
                end
            end

            // read of interrupt status clears only the bits returned
            if (acc && !pwrite && hit(paddr, `SLPS_IDX_IRQ_STAT)) begin
                next_s.irq_stat = s.irq_stat & ~s.rdata[1:0];
            end

            // writes take effect at the completing edge
            if (wr_ok) begin
                if (hit(paddr, `SLPS_IDX_LINK_ID)) begin
                    next_s.link_id = pwdata[7:0];
                end else if (hit(paddr, `SLPS_IDX_FRAME_END_CHAR_SELECT)) begin
                    next_s.frame_end_char_select_sel = pwdata[1:0];
                end else if (hit(paddr, `SLPS_IDX_STATUS)) begin
                    // only the sticky flags react; live bits ignore writes
                    if (pwdata[`SLPS_B_REALIGN]) begin
                        next_s.realigned = 1'b0;
                    end
                    if (pwdata[`SLPS_B_ALIGN]) begin
                        next_s.multiframe_phase_set = 1'b0;
                    end
                end else if (hit(paddr, `SLPS_IDX_IRQ_MASK)) begin
                    next_s.irq_mask = pwdata[1:0];
                end else if (hit(paddr, `SLPS_IDX_CTRL)) begin
                    next_s.link_en = pwdata[`SLPS_B_EN];
                end
            end

            // events after the clears, so a set in the same cycle wins
            if (sysref_shift) begin
                next_s.realigned = 1'b1;
                next_s.irq_stat[`SLPS_I_REALIGN] = 1'b1;
            end
            if (sysref_evt && s.armed) begin
                next_s.multiframe_phase_set = 1'b1;
                next_s.irq_stat[`SLPS_I_ALIGN] = 1'b1;
                next_s.armed = 1'b0;
            end
            if (!s.link_en) begin
                next_s.armed = 1'b0;
            end else if (!s.link_en_d) begin
                next_s.armed = 1'b1;
            end

            next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

            // lane character path
            next_s.tx.valid = oct.valid;
            next_s.tx.is_k = 1'b0;
            next_s.tx.data = oct.data;
            if (oct.ila_id_slot) begin
                next_s.tx.data = s.link_id;
            end else if (oct.frame_end && oct.subst_ok && mode_8b10b) begin
                // substitution only when the encoder allows it
                next_s.tx.is_k = 1'b1;
                next_s.tx.data = eof_char(s.frame_end_char_select_sel);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata = {`SLPS_PAD24, s.rdata};
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign tx = s.tx;
    assign serial_link_enable = s.link_en;
    assign irq = s.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_ila_ident: assert property (@(posedge pclk) disable iff (!presetn)
        ce && oct.ila_id_slot |=> tx.data == $past(s.link_id) && !tx.is_k)
        else $error("ila identifier octet wrong");

    a_eof_code: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !oct.ila_id_slot && oct.frame_end && oct.subst_ok && mode_8b10b
        |=> tx.is_k && tx.data == eof_char($past(s.frame_end_char_select_sel)))
        else $error("end-of-frame character wrong");

    a_no_subst: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !oct.subst_ok |=> !tx.is_k)
        else $error("control character without substitution permission");

    a_mode_gate: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !mode_8b10b |=> !tx.is_k)
        else $error("control character in non 8b10b mode");

    a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        ce && setup && hit(paddr, `SLPS_IDX_STATUS)
        |=> prdata[7:0] == $past(stat_val) && pready ##1 !pready)
        else $error("status read value or timing wrong");

    a_sync_level: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && sync_n) [*3] |-> s.sync_b)
        else $error("sync level not followed");

    a_realign_set: assert property (@(posedge pclk) disable iff (!presetn)
        ce && sysref_shift |=> s.realigned && s.irq_stat[`SLPS_I_REALIGN])
        else $error("realign flag not set");

    a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr_ok && hit(paddr, `SLPS_IDX_STATUS) && pwdata[`SLPS_B_ALIGN]
        && !(sysref_evt && s.armed) |=> !s.multiframe_phase_set)
        else $error("multiframe_phase_set flag not cleared by write one");

    a_first_sysref: assert property (@(posedge pclk) disable iff (!presetn)
        ce && sysref_evt && s.armed |=> s.multiframe_phase_set && !s.armed)
        else $error("multiframe_phase_set flag not set by first sysref");

    a_pll_lock: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !serializer_pll_lock) [*3] |-> !s.spll_b)
        else $error("serializer lock not followed");

    a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready && $past(ce && setup && hit(paddr, `SLPS_IDX_STATUS))
        |-> prdata[7] == 1'b0 && prdata[1] == 1'b0)
        else $error("reserved status bit reads one");

    // pll lock high for three cycles must reach the status view
    a_cpll_lock: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && converter_pll_lock) [*3] |-> s.cpll_b)
        else $error("converter lock not followed");

    // link_up is read raw, so the read must carry the value at setup
    a_link_live: assert property (@(posedge pclk) disable iff (!presetn)
        ce && setup && hit(paddr, `SLPS_IDX_STATUS)
        |=> prdata[`SLPS_B_LINK_UP] == $past(link_up))
        else $error("link up bit not shown");

    a_realign_hold: assert property (@(posedge pclk) disable iff (!presetn)
        s.realigned && !(ce && wr_ok && hit(paddr, `SLPS_IDX_STATUS)
        && pwdata[`SLPS_B_REALIGN]) |=> s.realigned)
        else $error("realign flag lost without a clear");

    a_align_hold: assert property (@(posedge pclk) disable iff (!presetn)
        s.multiframe_phase_set && !(ce && wr_ok && hit(paddr, `SLPS_IDX_STATUS)
        && pwdata[`SLPS_B_ALIGN]) |=> s.multiframe_phase_set)
        else $error("multiframe_phase_set flag lost without a clear");

    a_live_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr_ok && hit(paddr, `SLPS_IDX_STATUS)
        |=> s.sync_b == $past(s.sync_a) && s.spll_b == $past(s.spll_a)
        && s.cpll_b == $past(s.cpll_a))
        else $error("status write disturbed a live bit");

    a_frame_end_char_select_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
        ce && setup && hit(paddr, `SLPS_IDX_FRAME_END_CHAR_SELECT) |=> prdata[7:2] == 6'h00)
        else $error("reserved select bits read one");

    // irq is registered from the next copy, so it tracks the stored flags
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(s.irq_stat & s.irq_mask))
        else $error("interrupt level wrong");

    // unmapped words answer with an error and no data
    a_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
        ce && setup && !(hit(paddr, `SLPS_IDX_LINK_ID) || hit(paddr, `SLPS_IDX_FRAME_END_CHAR_SELECT)
        || hit(paddr, `SLPS_IDX_STATUS) || hit(paddr, `SLPS_IDX_IRQ_STAT)
        || hit(paddr, `SLPS_IDX_IRQ_MASK) || hit(paddr, `SLPS_IDX_CTRL))
        |=> pready && pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");

endmodule

/* test/slps_rx_model.sv */
// Purpose: receiver model on the far side of the lane encoder
// Assumes: one clock shared with the transmitter
// Notes: sync request is commanded by the bench
`timescale 1ns/100ps

module slps_rx_model import slps_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // characters from the transmitter
    input wire slps_txchar_t tx,
    // bench control and receiver outputs
    input wire logic hold_sync,
    output logic sync_n,
    output logic [7:0] last_k
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_n <= 1'h0;
            last_k <= 8'h00;
        end else begin
            // sync stays requested while the bench holds it
            sync_n <= ~hold_sync;
            if (tx.valid && tx.is_k) begin
                // generic 8b10b receiver, so selects 1 and 2 are allowed
                last_k <= tx.data;
            end
        end
    end
endmodule

/* test/slps_regs_bench.sv */
// Purpose: self-checking bench for slps_regs
// Assumes: slave answers in its own time; byte address = index * 4
// Notes: ce and pstrb held active throughout
`timescale 1ns/100ps
`include "slps_cfg.svh"

module slps_regs_bench import slps_pkg::*;;
    typedef struct packed {
        logic w;
        logic [9:0] idx;
        logic [7:0] wd;
        logic [31:0] rd;
        logic err;
    } slps_row_t;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic link_up = 1'h0;
    logic spll = 1'h0;
    logic cpll = 1'h0;
    logic sysref_evt = 1'h0;
    logic sysref_shift = 1'h0;
    logic mode_8b10b = 1'h0;
    logic hold_sync = 1'h0;
    slps_octet_t oct = 12'h000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    slps_txchar_t tx;
    logic link_en;
    logic irq;
    logic sync_n;
    logic [7:0] last_k;
    logic [31:0] rd;
    logic err;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    logic [7:0] kch [4] = '{`SLPS_K28_7, `SLPS_K28_1, `SLPS_K28_5, `SLPS_K28_7};
    slps_row_t rows [8] = '{
        '{1'h0, `SLPS_IDX_LINK_ID, 8'h00, 32'h0, 1'h0},
        '{1'h1, `SLPS_IDX_LINK_ID, 8'ha5, 32'h0, 1'h0},
        '{1'h0, `SLPS_IDX_LINK_ID, 8'h00, 32'ha5, 1'h0},
        '{1'h1, `SLPS_IDX_FRAME_END_CHAR_SELECT, 8'hff, 32'h0, 1'h0},
        '{1'h0, `SLPS_IDX_FRAME_END_CHAR_SELECT, 8'h00, 32'h3, 1'h0},
        '{1'h1, `SLPS_IDX_STATUS, 8'hff, 32'h0, 1'h0},
        '{1'h0, `SLPS_IDX_STATUS, 8'h00, 32'h20, 1'h0},
        '{1'h0, 10'h100, 8'h00, 32'h0, 1'h1}};

    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    slps_regs u_dut (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_up(link_up), .sync_n(sync_n), .serializer_pll_lock(spll),
        .converter_pll_lock(cpll), .sysref_evt(sysref_evt),
        .sysref_shift(sysref_shift), .mode_8b10b(mode_8b10b), .oct(oct), .tx(tx),
        .serial_link_enable(link_en), .irq(irq));
    slps_rx_model u_rx (.pclk(pclk), .presetn(presetn), .tx(tx),
        .hold_sync(hold_sync), .sync_n(sync_n), .last_k(last_k));

    always #2 pclk = ~pclk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'h1;
        // wait as long as the slave stalls; only the hang guard ends it
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 8'h00);
        chk(rd, exp);
    endtask

    task automatic pulse(input logic shift);
        @(posedge pclk);
        sysref_shift <= shift;
        sysref_evt <= ~shift;
        @(posedge pclk);
        sysref_shift <= 1'h0;
        sysref_evt <= 1'h0;
    endtask

    task automatic txchk(input logic [11:0] o, input logic m, input logic [9:0] e);
        @(posedge pclk);
        oct <= o;
        mode_8b10b <= m;
        repeat (2) @(posedge pclk);
        chk({22'h0, tx}, {22'h0, e});
    endtask

    task automatic irqchk(input logic e);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    // hang guard, well above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            stop_test;
        end
    end

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].idx, rows[i].wd);
            chk(rows[i].w ? rows[i].rd : rd, rows[i].rd);
            chk({31'h0, err}, {31'h0, rows[i].err});
        end
        $display("test table done");
        link_up <= 1'h1;
        spll <= 1'h1;
        cpll <= 1'h1;
        hold_sync <= 1'h1;
        repeat (5) @(posedge pclk);
        rdchk(`SLPS_IDX_STATUS, 32'h45);
        hold_sync <= 1'h0;
        repeat (5) @(posedge pclk);
        rdchk(`SLPS_IDX_STATUS, 32'h65);
        $display("test live bits done");
        apb(1'h1, `SLPS_IDX_CTRL, 8'h01);
        repeat (3) @(posedge pclk);
        chk({31'h0, link_en}, 32'h1);
        pulse(1'h0);
        rdchk(`SLPS_IDX_STATUS, 32'h6d);
        pulse(1'h1);
        rdchk(`SLPS_IDX_STATUS, 32'h7d);
        apb(1'h1, `SLPS_IDX_STATUS, 8'h00);
        rdchk(`SLPS_IDX_STATUS, 32'h7d);
        apb(1'h1, `SLPS_IDX_STATUS, 8'h10);
        rdchk(`SLPS_IDX_STATUS, 32'h6d);
        apb(1'h1, `SLPS_IDX_STATUS, 8'h08);
        rdchk(`SLPS_IDX_STATUS, 32'h65);
        $display("test flags done");
        irqchk(1'h0);
        apb(1'h1, `SLPS_IDX_IRQ_MASK, 8'h01);
        irqchk(1'h1);
        rdchk(`SLPS_IDX_IRQ_STAT, 32'h3);
        irqchk(1'h0);
        rdchk(`SLPS_IDX_IRQ_STAT, 32'h0);
        apb(1'h1, `SLPS_IDX_IRQ_MASK, 8'h00);
        pulse(1'h1);
        irqchk(1'h0);
        apb(1'h1, `SLPS_IDX_IRQ_MASK, 8'h01);
        irqchk(1'h1);
        apb(1'h1, `SLPS_IDX_CTRL, 8'h00);
        $display("test interrupt done");
        for (int s = 0; s < 4; s++) begin
            // select changed only with the link disabled
            apb(1'h1, `SLPS_IDX_FRAME_END_CHAR_SELECT, s[7:0]);
            txchk(12'he55, 1'h1, {2'h3, kch[s]});
        end
        chk({24'h0, last_k}, {24'h0, `SLPS_K28_7});
        txchk(12'ha55, 1'h1, 10'h255);
        txchk(12'he55, 1'h0, 10'h255);
        txchk(12'h955, 1'h1, 10'h2a5);
        oct <= 12'h000;
        $display("test encoder done");
        // reset in mid-run must clear outputs and restore register defaults
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        chk({20'h0, irq, tx, link_en}, 32'h0);
        chk(prdata, 32'h0);
        presetn <= 1'h1;
        rdchk(`SLPS_IDX_LINK_ID, 32'h0);
        rdchk(`SLPS_IDX_FRAME_END_CHAR_SELECT, 32'h0);
        $display("test reset done");
        stop_test;
    end
endmodule
